// file: hw/mftr_consts.vh
// Constants for the multifunction terminal router
`ifndef MFTR_CONSTS_VH
`define MFTR_CONSTS_VH

// Configuration space location of the routing register
`define MFTR_ROUTE_OFS 8'h8c
// Implemented selector bits (terminals 0 to 5)
`define MFTR_ROUTE_W 24
`define MFTR_ROUTE_RST 24'h000000

// Field positions of each terminal selector
`define MFTR_T0_LSB 0
`define MFTR_T1_LSB 4
`define MFTR_T2_LSB 8
`define MFTR_T3_LSB 12
`define MFTR_T4_LSB 16
`define MFTR_T5_LSB 20
`define MFTR_SEL_W 4

// Selector codes
`define MFTR_SEL_GPI 4'h0
`define MFTR_SEL_GPO 4'h1
`define MFTR_SEL_SERIRQ 4'h1
`define MFTR_SEL_ALT 4'h2
`define MFTR_SEL_IRQ3 4'h3
`define MFTR_SEL_IRQ4 4'h4
`define MFTR_SEL_IRQ5 4'h5
`define MFTR_SEL_VSTAT 4'h6
`define MFTR_SEL_VSEL 4'h7
`define MFTR_SEL_AUDIO 4'h8
`define MFTR_SEL_IRQ9 4'h9
`define MFTR_SEL_RING 4'ha
`define MFTR_SEL_IRQ11 4'hb
`define MFTR_SEL_LED 4'hc
`define MFTR_SEL_IRQ13 4'hd
`define MFTR_SEL_EVENT 4'he
`define MFTR_SEL_IRQ15 4'hf

// Idle level returned for an input that is not routed
`define MFTR_IN_IDLE 1'b1

`endif

// file: hw/mftr_router.v
// Multifunction terminal router for terminals 0 to 5
//
// Function
// - Terminal 5 selector in bits 23:20, reset 0000 gives general input 4.
// - Terminal 5 code 0010 carries DMA grant, code 1110 general event.
// - Terminal 4 selector in bits 19:16, code 0010 carries PCI lock.
// - Serial bus strap forces terminal 4 to serial clock.
// - Serial bus strap forces terminal 1 to serial data.
// - Terminal 3 selector in bits 15:12, reset 0000 is undriven input.
// - Terminal 3 code 0001 carries the serial interrupt stream.
// - Terminal 3 codes 0010 to 1111 drive interrupt line of same number.
// - Terminal 2 selector in bits 11:8, code 0010 drives DMA request.
// - Terminal 2 code 1111 drives interrupt line 7.
// - Terminal 0 selector in bits 3:0, code 0010 drives PCI interrupt A.
// - Terminals 0,1,2,4,5 reset to inputs 0-4; code 0001 gives outputs.
// - Codes 0011, 0100, 0101 drive lines 3, 4, 5; code 1001 line 9.
// - Code 0110 video status on five pins; 0111 video select except pin 4.
// - Code 1000 drives audio pulse signal on five pins.
// - Terminal 1 code 1100 drives activity LED, code 1110 general event.
// - Code 1111 drives line 15 on terminals 0, 1, 4, 5.
// - Terminals 2 and 4 offer ring-indicate output.
// - Routing value may be loaded from serial EEPROM instead of reset.
// - Ring output reaches pins only while ring output enable is set.
`timescale 1ns/1ps
`include "mftr_consts.vh"
module mftr_router #(
   parameter NPIN = 6,
   parameter NGP = 5
) (
   input wire clock_i,                 // PCI clock, 40 MHz
   input wire rst_b_i,                 // PCI reset, synchronous, active low
   input wire cfg_wr_i,                // Config write strobe
   input wire cfg_rd_i,                // Config read strobe
   input wire [7:0] cfg_addr_i,        // Config byte offset, dword aligned
   input wire [3:0] cfg_be_i,          // Config byte enables
   input wire [31:0] cfg_wdata_i,      // Config write data
   output reg [31:0] cfg_rdata_o,      // Config read data
   input wire eeprom_load_i,           // EEPROM default load strobe
   input wire [23:0] eeprom_data_i,    // EEPROM routing default
   input wire power_switch_ctl_0_i,    // Strap pin 0
   input wire power_switch_ctl_1_i,    // Strap pin 1
   input wire [NPIN-1:0] pin_i,        // Terminal input levels
   output reg [NPIN-1:0] pin_o,        // Terminal output levels
   output reg [NPIN-1:0] pin_oe_o,     // Terminal drive enables
   input wire [NGP-1:0] gp_output_i,   // General output data
   output reg [NGP-1:0] gp_input_o,    // General input status
   input wire [15:0] isa_irq_i,        // Parallel interrupt levels
   input wire serial_irq_stream_i,     // Serial irq data to send
   input wire serial_irq_oe_i,         // Serial irq drive enable
   output reg serial_irq_in_o,         // Serial irq line level
   output reg central_dma_grant_o,     // Sampled DMA grant
   input wire central_dma_request_i,   // DMA request to drive
   input wire lock_out_i,              // PCI lock level to drive
   input wire lock_oe_i,               // PCI lock drive enable
   output reg lock_in_o,               // PCI lock line level
   input wire inta_i,                  // PCI interrupt A level
   input wire video_port_status_i,     // Video status
   input wire video_port_select_i,     // Video select
   input wire card_audio_pin_i,        // Card audio pulse input
   input wire socket_activity_led_i,   // Activity LED level
   input wire general_event_out_i,     // General event level
   input wire ring_indicate_out_i,     // Ring indicate level
   input wire ring_output_enable_i,    // Ring output enable bit
   input wire scl_oe_i,                // Serial bus clock pull-low
   input wire sda_oe_i,                // Serial bus data pull-low
   output reg scl_in_o,                // Serial bus clock level
   output reg sda_in_o,                // Serial bus data level
   output reg serial_bus_mode_o        // Serial bus mode strapped
);

   // Source bundle positions inside the routing function
   localparam S_VSTAT = 0;
   localparam S_VSEL = 1;
   localparam S_AUDIO = 2;
   localparam S_LED = 3;
   localparam S_EVENT = 4;
   localparam S_RING = 5;
   localparam S_RING_EN = 6;
   localparam S_INTA = 7;
   localparam S_DREQ = 8;
   localparam S_LOCK = 9;
   localparam S_LOCK_OE = 10;
   localparam S_SIRQ = 11;
   localparam S_SIRQ_OE = 12;
   localparam NSRC = 13;

   reg [`MFTR_ROUTE_W-1:0] route;
   wire [NPIN-1:0] pin_s;
   wire sb_mode;
   wire [NSRC-1:0] src;
   reg [NPIN-1:0] next_pin_o;
   reg [NPIN-1:0] next_pin_oe;
   reg [1:0] drv;
   integer t;

   // Selector of one terminal
   function [3:0] sel_of;
      input [`MFTR_ROUTE_W-1:0] r;
      input integer term;
      begin
         sel_of = r[term*`MFTR_SEL_W +: `MFTR_SEL_W];
      end
   endfunction

   // General input/output index of terminals 0,1,2,4,5
   function [2:0] gp_idx;
      input integer term;
      begin
         gp_idx = (term < 3) ? term[2:0] : term[2:0] - 3'd1;
      end
   endfunction

   // Drive decision {oe, level} for one terminal and selector
   function [1:0] pin_drive;
      input integer term;
      input [3:0] sel;
      input [15:0] irq;
      input [NSRC-1:0] s;
      input gpo;
      begin
         // Undriven unless a branch below claims the pin; reserved codes stay off
         pin_drive = 2'b00;
         if (term == 3) begin
            if (sel == `MFTR_SEL_GPI)
               pin_drive = 2'b00;
            else if (sel == `MFTR_SEL_SERIRQ)
               pin_drive = {s[S_SIRQ_OE], s[S_SIRQ]};
            else
               pin_drive = {1'b1, irq[sel]};
         end else begin
            case (sel)
               `MFTR_SEL_GPI: pin_drive = 2'b00;
               `MFTR_SEL_GPO: pin_drive = {1'b1, gpo};
               `MFTR_SEL_ALT: begin
                  if (term == 0)
                     pin_drive = {1'b1, s[S_INTA]};
                  else if (term == 1)
                     pin_drive = {1'b1, irq[2]};
                  else if (term == 2)
                     pin_drive = {1'b1, s[S_DREQ]};
                  else if (term == 4)
                     pin_drive = {s[S_LOCK_OE], s[S_LOCK]};
                  else
                     pin_drive = 2'b00;
               end
               `MFTR_SEL_IRQ3, `MFTR_SEL_IRQ4, `MFTR_SEL_IRQ5,
               `MFTR_SEL_IRQ9: pin_drive = {1'b1, irq[sel]};
               `MFTR_SEL_VSTAT: pin_drive = {1'b1, s[S_VSTAT]};
               `MFTR_SEL_VSEL: begin
                  if (term != 4)
                     pin_drive = {1'b1, s[S_VSEL]};
               end
               `MFTR_SEL_AUDIO: pin_drive = {1'b1, s[S_AUDIO]};
               `MFTR_SEL_RING: begin
                  if (term == 2 || term == 4)
                     pin_drive = {s[S_RING_EN], s[S_RING]};
                  else
                     pin_drive = {1'b1, irq[10]};
               end
               `MFTR_SEL_IRQ11: begin
                  if (term != 5)
                     pin_drive = {1'b1, irq[11]};
               end
               `MFTR_SEL_LED: begin
                  if (term != 2 && term != 4)
                     pin_drive = {1'b1, s[S_LED]};
               end
               `MFTR_SEL_IRQ13: begin
                  if (term < 2)
                     pin_drive = {1'b1, irq[13]};
               end
               `MFTR_SEL_EVENT: pin_drive = {1'b1, s[S_EVENT]};
               default: begin
                  if (term == 2)
                     pin_drive = {1'b1, irq[7]};
                  else
                     pin_drive = {1'b1, irq[15]};
               end
            endcase
         end
      end
   endfunction

   // Inputs are synchronised before any use
   mftr_sync #(
      .W(NPIN)
   ) u_sync (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .d_i(pin_i),
      .q_o(pin_s)
   );

   // Serial bus strap caught after reset release
   mftr_strap u_strap (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .power_switch_ctl_0_i(power_switch_ctl_0_i),
      .power_switch_ctl_1_i(power_switch_ctl_1_i),
      .serial_mode_o(sb_mode)
   );

   // Internal sources gathered for the routing function
   assign src = {serial_irq_oe_i, serial_irq_stream_i, lock_oe_i, lock_out_i,
                 central_dma_request_i, inta_i, ring_output_enable_i,
                 ring_indicate_out_i, general_event_out_i, socket_activity_led_i,
                 card_audio_pin_i, video_port_select_i, video_port_status_i};

   // Routing register; EEPROM load beats a config write in the same cycle
   always @(posedge clock_i) begin
      if (!rst_b_i) begin
         route <= `MFTR_ROUTE_RST;
      end else if (eeprom_load_i) begin
         route <= eeprom_data_i;
      end else if (cfg_wr_i && cfg_addr_i == `MFTR_ROUTE_OFS) begin
         if (cfg_be_i[0])
            route[7:0] <= cfg_wdata_i[7:0];
         if (cfg_be_i[1])
            route[15:8] <= cfg_wdata_i[15:8];
         if (cfg_be_i[2])
            route[23:16] <= cfg_wdata_i[23:16];
      end
   end

   // Read data; upper byte reads zero, unmapped offsets read zero
   always @(posedge clock_i) begin
      if (!rst_b_i)
         cfg_rdata_o <= 32'h00000000;
      else if (cfg_rd_i && cfg_addr_i == `MFTR_ROUTE_OFS)
         cfg_rdata_o <= {8'h00, route};
      else
         cfg_rdata_o <= 32'h00000000;
   end

   // Per-terminal drive decision; serial bus strap overrides the selectors of terminals 1 and 4
   always @* begin
      next_pin_o = {NPIN{1'b0}};
      next_pin_oe = {NPIN{1'b0}};
      drv = 2'b00;
      for (t = 0; t < NPIN; t = t + 1) begin
         drv = pin_drive(t, sel_of(route, t), isa_irq_i, src,
                         gp_output_i[gp_idx(t)]);
         if (sb_mode && t == 4)
            drv = {scl_oe_i, 1'b0};
         else if (sb_mode && t == 1)
            drv = {sda_oe_i, 1'b0};
         next_pin_oe[t] = drv[1];
         next_pin_o[t] = drv[1] & drv[0];
      end
   end

   // Registered pin drive, one clock behind the sources
   always @(posedge clock_i) begin
      if (!rst_b_i) begin
         pin_o <= {NPIN{1'b0}};
         pin_oe_o <= {NPIN{1'b0}};
      end else begin
         pin_o <= next_pin_o;
         pin_oe_o <= next_pin_oe;
      end
   end

   // General input status: synchronised level while routed as input
   always @(posedge clock_i) begin
      if (!rst_b_i) begin
         gp_input_o <= {NGP{1'b0}};
      end else begin
         gp_input_o[0] <= (sel_of(route, 0) == `MFTR_SEL_GPI) & pin_s[0];
         gp_input_o[1] <= (sel_of(route, 1) == `MFTR_SEL_GPI) & !sb_mode & pin_s[1];
         gp_input_o[2] <= (sel_of(route, 2) == `MFTR_SEL_GPI) & pin_s[2];
         gp_input_o[3] <= (sel_of(route, 4) == `MFTR_SEL_GPI) & !sb_mode & pin_s[4];
         gp_input_o[4] <= (sel_of(route, 5) == `MFTR_SEL_GPI) & pin_s[5];
      end
   end

   // Returned input levels; idle high when the function is not routed
   always @(posedge clock_i) begin
      if (!rst_b_i) begin
         central_dma_grant_o <= `MFTR_IN_IDLE;
         lock_in_o <= `MFTR_IN_IDLE;
         serial_irq_in_o <= `MFTR_IN_IDLE;
         scl_in_o <= `MFTR_IN_IDLE;
         sda_in_o <= `MFTR_IN_IDLE;
         serial_bus_mode_o <= 1'b0;
      end else begin
         central_dma_grant_o <= (sel_of(route, 5) == `MFTR_SEL_ALT) ?
                                pin_s[5] : `MFTR_IN_IDLE;
         lock_in_o <= (sel_of(route, 4) == `MFTR_SEL_ALT && !sb_mode) ?
                      pin_s[4] : `MFTR_IN_IDLE;
         serial_irq_in_o <= (sel_of(route, 3) == `MFTR_SEL_SERIRQ) ?
                            pin_s[3] : `MFTR_IN_IDLE;
         scl_in_o <= sb_mode ? pin_s[4] : `MFTR_IN_IDLE;
         sda_in_o <= sb_mode ? pin_s[1] : `MFTR_IN_IDLE;
         serial_bus_mode_o <= sb_mode;
      end
   end

endmodule // mftr_router

// file: hw/mftr_strap.v
// Serial bus mode strap capture
`timescale 1ns/1ps
module mftr_strap (
   input wire clock_i,             // PCI clock
   input wire rst_b_i,             // Synchronous reset, active low
   input wire power_switch_ctl_0_i, // Strap level on switch control 0
   input wire power_switch_ctl_1_i, // Strap level on switch control 1
   output reg serial_mode_o        // Both pulled up: serial bus mode
);
   reg done;

   // Sampled once, first cycle after reset release; pins later toggle
   always @(posedge clock_i) begin
      if (!rst_b_i) begin
         done <= 1'b0;
         serial_mode_o <= 1'b0;
      end else if (!done) begin
         done <= 1'b1;
         serial_mode_o <= power_switch_ctl_0_i & power_switch_ctl_1_i;
      end
   end
endmodule // mftr_strap

// file: hw/mftr_sync.v
// Two-stage synchroniser for the terminal input levels
`timescale 1ns/1ps
module mftr_sync #(
   parameter W = 6
) (
   input wire clock_i,        // PCI clock
   input wire rst_b_i,        // Synchronous reset, active low
   input wire [W-1:0] d_i,    // Raw pin levels
   output reg [W-1:0] q_o     // Synchronised levels
);
   reg [W-1:0] meta;

   // First stage feeds only the second
   always @(posedge clock_i) begin
      if (!rst_b_i) begin
         meta <= {W{1'b1}};
         q_o <= {W{1'b1}};
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule // mftr_sync

// file: test/mftr_board.sv
// Board-side model of the wiring around the six terminals
`timescale 1ns/1ps
module mftr_board (
   input wire [5:0] drv_lvl_i, // Router levels
   input wire [5:0] drv_en_i, // Router enables
   input wire [5:0] ext_en_i, // Other board drivers active
   input wire [5:0] ext_i, // Their levels
   input wire strap_i, // Serial bus strap fitted
   output wire [5:0] wire_o, // Wire levels
   output wire psc_o // Both switch control lines
);
   // Router wins, then another driver, else the pull-up; never a stale level
   assign wire_o = (drv_en_i & drv_lvl_i) |
                   (~drv_en_i & ((ext_en_i & ext_i) | ~ext_en_i));
   // Pull-ups on both control lines only when the strap is fitted
   assign psc_o = strap_i;
endmodule // mftr_board

// file: test/mftr_router_assertions.sv
// Concurrent checks on the terminal router ports
`timescale 1ns/1ps
module mftr_router_assertions #(
   parameter NPIN = 6,
   parameter NGP = 5
) (
   input wire clock_i, // Clock
   input wire rst_b_i, // Reset
   input wire cfg_wr_i, // Write strobe
   input wire cfg_rd_i, // Read strobe
   input wire [7:0] cfg_addr_i, // Offset
   input wire [3:0] cfg_be_i, // Byte enables
   input wire [31:0] cfg_wdata_i, // Write data
   input wire [31:0] cfg_rdata_o, // Read data
   input wire eeprom_load_i, // Default load
   input wire [23:0] eeprom_data_i, // Default value
   input wire [NPIN-1:0] pin_o, // Levels
   input wire [NPIN-1:0] pin_oe_o, // Enables
   input wire [15:0] isa_irq_i, // Interrupt lines
   input wire inta_i, // Interrupt A
   input wire central_dma_request_i, // DMA request
   input wire general_event_out_i, // Event level
   input wire scl_oe_i, // Clock pull-low
   input wire serial_bus_mode_o // Strap result
);
   reg [23:0] sh;
   reg [23:0] sh_q;
   reg [15:0] irq_q;
   wire [23:0] m;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   assign m = {{8{cfg_be_i[2]}}, {8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};
   // Shadow routing; sh_q lags one edge because the decode is registered
   always @(posedge clock_i) begin
      if (!rst_b_i) sh <= 24'h000000;
      else if (eeprom_load_i) sh <= eeprom_data_i;
      else if (cfg_wr_i && cfg_addr_i == 8'h8c) sh <= (sh & ~m) | (cfg_wdata_i[23:0] & m);
      sh_q <= rst_b_i ? sh : 24'h000000;
      irq_q <= isa_irq_i;
   end
   property p_read;
      cfg_rd_i && !cfg_wr_i && !eeprom_load_i && cfg_addr_i == 8'h8c |=> cfg_rdata_o == {8'h00, $past(sh)};
   endproperty
   a_read: assert property (p_read) else $error("routing read back wrong");
   property p_t0_inta;
      sh_q[3:0] == 4'h2 |-> pin_oe_o[0] && pin_o[0] == $past(inta_i);
   endproperty
   a_t0_inta: assert property (p_t0_inta) else $error("terminal 0 lacks int A");
   property p_t2_req;
      sh_q[11:8] == 4'h2 |-> pin_oe_o[2] && pin_o[2] == $past(central_dma_request_i);
   endproperty
   a_t2_req: assert property (p_t2_req) else $error("terminal 2 lacks DMA request");
   property p_t2_irq7;
      sh_q[11:8] == 4'hf |-> pin_oe_o[2] && pin_o[2] == irq_q[7];
   endproperty
   a_t2_irq7: assert property (p_t2_irq7) else $error("terminal 2 code f not line 7");
   property p_t3_irq;
      sh_q[15:12] >= 4'h2 |-> pin_oe_o[3] && pin_o[3] == irq_q[sh_q[15:12]];
   endproperty
   a_t3_irq: assert property (p_t3_irq) else $error("terminal 3 wrong line");
   property p_t3_idle;
      (sh[15:12] == 4'h0) [*3] |=> !pin_oe_o[3] && !pin_o[3];
   endproperty
   a_t3_idle: assert property (p_t3_idle) else $error("terminal 3 driven at code 0");
   property p_t5_event;
      sh_q[23:20] == 4'he |-> pin_oe_o[5] && pin_o[5] == $past(general_event_out_i);
   endproperty
   a_t5_event: assert property (p_t5_event) else $error("terminal 5 lacks event");
   property p_scl;
      serial_bus_mode_o && $past(serial_bus_mode_o) |-> pin_oe_o[4] == $past(scl_oe_i) && !pin_o[4];
   endproperty
   a_scl: assert property (p_scl) else $error("terminal 4 not serial clock");
   // Main scenarios reached
   c_irq: cover property (sh_q[15:12] >= 4'h2);
   c_serial: cover property (serial_bus_mode_o);
   c_load: cover property (eeprom_load_i ##[1:12] cfg_rd_i);
endmodule // mftr_router_assertions

bind mftr_router mftr_router_assertions #(.NPIN(NPIN), .NGP(NGP)) u_chk (
   .clock_i(clock_i), .rst_b_i(rst_b_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
   .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i),
   .cfg_rdata_o(cfg_rdata_o), .eeprom_load_i(eeprom_load_i), .eeprom_data_i(eeprom_data_i),
   .pin_o(pin_o), .pin_oe_o(pin_oe_o), .isa_irq_i(isa_irq_i), .inta_i(inta_i),
   .central_dma_request_i(central_dma_request_i), .general_event_out_i(general_event_out_i),
   .scl_oe_i(scl_oe_i), .serial_bus_mode_o(serial_bus_mode_o));

// file: test/tb.sv
// Self-checking bench for the terminal router
`timescale 1ns/1ps
module tb;
   typedef struct packed {logic rd; logic [31:0] v;} mftr_note_t;
   reg clock_i = 0, rst_b_i = 0, cfg_wr_i = 0, cfg_rd_i = 0, eeprom_load_i = 0, strap = 0;
   reg [7:0] cfg_addr_i = 8'h00;
   reg [3:0] cfg_be_i = 4'h0;
   reg [31:0] cfg_wdata_i = 32'h0, rnd = 32'h0, seen;
   reg [23:0] eeprom_data_i = 24'h0, route = 24'h0;
   reg [4:0] gp_output_i = 5'h00;
   reg [15:0] isa_irq_i = 16'h0000;
   reg [14:0] mi = 15'h0000; // Single-bit sources
   reg [5:0] ext = 6'h00, ext_en = 6'h00;
   wire [5:0] pin_i, pin_o, pin_oe_o;
   wire [4:0] gp_input_o;
   wire [31:0] cfg_rdata_o;
   wire psc, grant, serirq, lock_in, scl_in, sda_in, mode;
   integer seed = 32'h4d4c, n_mismatch = 0, samples_checked = 0;
   mftr_note_t q[$], nt;
   mftr_router uut (.clock_i(clock_i), .rst_b_i(rst_b_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
      .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i),
      .cfg_rdata_o(cfg_rdata_o), .eeprom_load_i(eeprom_load_i), .eeprom_data_i(eeprom_data_i),
      .power_switch_ctl_0_i(psc), .power_switch_ctl_1_i(psc), .pin_i(pin_i), .pin_o(pin_o),
      .pin_oe_o(pin_oe_o), .gp_output_i(gp_output_i), .gp_input_o(gp_input_o),
      .isa_irq_i(isa_irq_i), .serial_irq_stream_i(mi[0]), .serial_irq_oe_i(mi[1]),
      .serial_irq_in_o(serirq), .central_dma_grant_o(grant), .central_dma_request_i(mi[2]),
      .lock_out_i(mi[3]), .lock_oe_i(mi[4]), .lock_in_o(lock_in), .inta_i(mi[5]),
      .video_port_status_i(mi[6]), .video_port_select_i(mi[7]), .card_audio_pin_i(mi[8]),
      .socket_activity_led_i(mi[9]), .general_event_out_i(mi[10]), .ring_indicate_out_i(mi[11]),
      .ring_output_enable_i(mi[12]), .scl_oe_i(mi[13]), .sda_oe_i(mi[14]), .scl_in_o(scl_in),
      .sda_in_o(sda_in), .serial_bus_mode_o(mode));
   mftr_board board (.drv_lvl_i(pin_o), .drv_en_i(pin_oe_o), .ext_en_i(ext_en), .ext_i(ext),
      .strap_i(strap), .wire_o(pin_i), .psc_o(psc));
   // 40 MHz clock
   initial forever #12.5 clock_i = ~clock_i;
   // Expected {enable, level} of one terminal; reserved codes leave it undriven
   function automatic [1:0] drv(input integer t, input [3:0] c);
      reg o, v;
      begin
         case (c)
            4'h1: v = gp_output_i[t < 3 ? t : t - 1];
            4'h2: v = t == 0 ? mi[5] : t == 1 ? isa_irq_i[2] : t == 2 ? mi[2] : mi[3];
            4'h6: v = mi[6];
            4'h7: v = mi[7];
            4'h8: v = mi[8];
            4'ha: v = (t == 2 || t == 4) ? mi[11] : isa_irq_i[10];
            4'hc: v = mi[9];
            4'he: v = mi[10];
            4'hf: v = isa_irq_i[t == 2 ? 7 : 15];
            default: v = isa_irq_i[c];
         endcase
         o = c != 0 && !(c == 2 && t == 5) && !(c == 7 && t == 4) && !(c == 4'hb && t == 5)
            && !(c == 4'hc && (t == 2 || t == 4)) && !(c == 4'hd && t > 1);
         if (c == 2 && t == 4) o = mi[4];
         if (c == 4'ha && (t == 2 || t == 4)) o = mi[12];
         if (t == 3) o = c > 1 || (c == 1 && mi[1]);
         if (t == 3 && c > 1) v = isa_irq_i[c];
         if (t == 3 && c == 1) v = mi[0];
         if (strap && (t == 1 || t == 4)) o = t == 1 ? mi[14] : mi[13];
         if (strap && (t == 1 || t == 4)) v = 1'b0;
         drv = {o, o & v};
      end
   endfunction
   // Whole expected port state for a routing value
   function automatic [22:0] exp_state(input [23:0] r);
      reg [5:0] po, oe, lv;
      reg [4:0] gp;
      reg [1:0] d;
      integer t;
      begin
         for (t = 0; t < 6; t = t + 1) begin
            d = drv(t, r[4*t +: 4]);
            {oe[t], po[t]} = d;
            lv[t] = d[1] ? d[0] : (ext_en[t] ? ext[t] : 1'b1);
            if (t != 3) gp[t < 3 ? t : t - 1] = r[4*t +: 4] == 0 && !(strap && (t == 1 || t == 4)) && lv[t];
         end
         exp_state = {po, oe, gp, r[23:20] == 2 ? lv[5] : 1'b1, r[15:12] == 1 ? lv[3] : 1'b1,
            r[19:16] == 2 && !strap ? lv[4] : 1'b1, strap ? lv[4] : 1'b1, strap ? lv[1] : 1'b1, strap};
      end
   endfunction
   // One access: 0 read, 1 write, 2 default load; strobes stand across one edge
   task op(input [1:0] k, input [7:0] a, input [3:0] be, input [31:0] d);
      reg [23:0] m;
      begin
         m = {{8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
         @(negedge clock_i);
         {eeprom_load_i, cfg_wr_i, cfg_rd_i} = {k == 2, k == 1, k == 0};
         {cfg_addr_i, cfg_be_i, cfg_wdata_i, eeprom_data_i} = {a, be, d, d[23:0]};
         @(negedge clock_i);
         {eeprom_load_i, cfg_wr_i, cfg_rd_i} = 3'b000;
         if (k == 2) route = d[23:0];
         if (k == 1 && a == 8'h8c) route = (route & ~m) | (d[23:0] & m);
         if (k == 0) q.push_back({1'b1, a == 8'h8c ? {8'h00, route} : 32'h0});
      end
   endtask
   // Let decode and input synchronisers settle, then note the state
   task settle;
      begin
         repeat (6) @(negedge clock_i);
         q.push_back({1'b0, 9'h000, exp_state(route)});
      end
   endtask
   // Sweep each code on all terminals, then random routing by write or load
   task run(input integer n);
      integer i;
      begin
         for (i = 0; i < n; i = i + 1) begin
            @(negedge clock_i);
            rnd = $random(seed);
            {gp_output_i, mi, ext} = rnd[25:0];
            rnd = $random(seed);
            {isa_irq_i, ext_en} = rnd[21:0];
            rnd = $random(seed);
            if (i < 16) op(1, 8'h8c, 4'hf, {8'hff, {6{i[3:0]}}});
            else op(i[0] ? 2'd2 : 2'd1, 8'h8c, rnd[27:24], rnd);
            settle;
            op(0, 8'h8c, 4'h0, 32'h0);
         end
      end
   endtask
   // Oldest note against the settled outputs
   always @(negedge clock_i) begin
      #2;
      while (q.size() > 0) begin
         nt = q.pop_front();
         seen = nt.rd ? cfg_rdata_o : {9'h000, pin_o, pin_oe_o, gp_input_o, grant, serirq, lock_in,
            scl_in, sda_in, mode};
         samples_checked = samples_checked + 1;
         if (seen !== nt.v) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch %s expected %h seen %h", nt.rd ? "cfg_rdata" : "terminal_state", nt.v, seen);
         end
      end
   end
   // Main sequence; second reset fits the serial bus strap
   initial begin
      repeat (10) @(negedge clock_i);
      rst_b_i = 1;
      settle;
      op(0, 8'h8c, 4'h0, 32'h0);
      run(48);
      op(1, 8'h90, 4'hf, 32'hffffffff);
      op(0, 8'h90, 4'h0, 32'h0);
      op(0, 8'h8c, 4'h0, 32'h0);
      rst_b_i = 0;
      strap = 1;
      route = 24'h000000;
      repeat (10) @(negedge clock_i);
      rst_b_i = 1;
      run(20);
      repeat (2) @(negedge clock_i);
      wrap_up;
   end
   // Hang guard, about twenty-five times the expected run
   initial begin
      #(25 * 20000);
      n_mismatch = n_mismatch + 1;
      wrap_up;
   end
   task wrap_up;
      begin
         if (n_mismatch == 0 && samples_checked > 0) begin
            $display("STATUS OK");
         end else begin
            $display("STATUS NOT OK");
         end
         $finish;
      end
   endtask
endmodule // tb
